// file: inc/aofr_pkg.sv
// Package with register map, field layout and encodings of the output format block.
package aofr_pkg;
  // Register addresses on the serial configuration word.
  localparam logic [6:0] ADDR_RESET_CTRL   = 7'h00;
  localparam logic [6:0] ADDR_DRIVE_CONFIG = 7'h03;
  localparam logic [6:0] ADDR_DATA_FORMAT  = 7'h04;
  localparam logic [7:0] REG_RESET_VALUE   = 8'h00;
  localparam int         RESET_BIT         = 7;
  // Serial word layout.
  localparam int         WORD_BITS         = 16;
  localparam logic [4:0] WORD_LAST         = 5'h10;
  // Output drive config fields.
  localparam int         DRV_CUR_HI        = 6;
  localparam int         DRV_CUR_LO        = 4;
  localparam int         DRV_TERM_BIT      = 3;
  localparam int         DRV_OFF_BIT       = 2;
  localparam int         DRV_FMT_HI        = 1;
  localparam int         DRV_FMT_LO        = 0;
  // Data format fields.
  localparam int         FMT_TEST_HI       = 5;
  localparam int         FMT_TEST_LO       = 3;
  localparam int         FMT_ABP_BIT       = 2;
  localparam int         FMT_OUTPUT_SCRAMBLER_EN_BIT      = 1;
  localparam int         FMT_SIGNED_BIT    = 0;
  // Test pattern codes.
  localparam logic [2:0] TP_OFF            = 3'h0;
  localparam logic [2:0] TP_ZEROS          = 3'h1;
  localparam logic [2:0] TP_ONES           = 3'h3;
  localparam logic [2:0] TP_CHECKER        = 3'h5;
  localparam logic [2:0] TP_ALTERNATE      = 3'h7;
  // Drive current in units of 0.01 mA, termination scale in tenths.
  localparam logic [11:0] CUR_3P5  = 12'h15e;
  localparam logic [11:0] CUR_4P0  = 12'h190;
  localparam logic [11:0] CUR_4P5  = 12'h1c2;
  localparam logic [11:0] CUR_3P0  = 12'h12c;
  localparam logic [11:0] CUR_2P5  = 12'h0fa;
  localparam logic [11:0] CUR_2P1  = 12'h0d2;
  localparam logic [11:0] CUR_1P75 = 12'h0af;
  localparam logic [11:0] TERM_NUM = 12'h010;
  localparam logic [11:0] TERM_DEN = 12'h00a;
  localparam logic [15:0] CHECKER_A = 16'h5554;
  localparam logic [15:0] CHECKER_B = 16'haaa8;
  localparam logic [15:0] ABP_MASK  = 16'haaaa;
  typedef enum logic [1:0] {
    FMT_CMOS_FULL = 2'h0,
    FMT_CMOS_DDR  = 2'h1,
    FMT_LVDS_DDR  = 2'h2,
    FMT_UNUSED    = 2'h3
  } aofr_fmt_type;
endpackage : aofr_pkg

// file: inc/aofr_ser_if.sv
// Interface carrying decoded serial commands between the port and the registers.
`timescale 1ns/1ps
`default_nettype none
interface aofr_ser_if;
  logic       wrStb;
  logic [6:0] addr;
  logic [7:0] wrData;
  logic       rdLoad;
  logic [7:0] rdData;
  modport port (output wrStb, output addr, output wrData, output rdLoad,
                input rdData);
  modport regs (input wrStb, input addr, input wrData, input rdLoad,
                output rdData);
endinterface : aofr_ser_if
`default_nettype wire

// file: design/aofr_serial_port.sv
// Serial configuration port: shifts 16-bit words and shifts out read data.
`timescale 1ns/1ps
`default_nettype none
module aofr_serial_port
  import aofr_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Serial pins, sampled on clk.
  input  wire logic csN,
  input  wire logic sck,
  input  wire logic sdi,
  output logic      sdoOe,
  // Decoded commands.
  aofr_ser_if.port  bus
);
  logic [4:0]  bitCount;
  logic [14:0] shiftIn;
  logic [7:0]  shiftOut;
  logic        sckLast;
  logic        readCmd;
  wire         sckRise = sck & ~sckLast;
  wire         takeBit = ~csN & sckRise & (bitCount != WORD_LAST);
  wire  [4:0]  next_bitCount = bitCount + 5'h01;

  // Edges past the sixteenth are ignored; the count holds.
  always_ff @(posedge clk) begin
    sckLast <= sck;
    if (rst || csN) begin
      bitCount <= 5'h00;
      readCmd  <= 1'b0;
    end else if (takeBit) begin
      bitCount <= next_bitCount;
      shiftIn  <= {shiftIn[13:0], sdi};
      if (bitCount == 5'h00) readCmd <= sdi;
    end
    if (rst) shiftOut <= 8'h00;
    else if (bus.rdLoad) shiftOut <= bus.rdData;
    else if (takeBit && bitCount > 5'h07) shiftOut <= {shiftOut[6:0], 1'b0};
  end

  // Word is read/write flag, seven address bits, eight data bits.
  assign bus.addr   = (bitCount == 5'h07 && takeBit) ? {shiftIn[5:0], sdi}
                                                     : shiftIn[13:7];
  assign bus.wrData = {shiftIn[6:0], sdi};
  assign bus.wrStb  = takeBit && bitCount == 5'(WORD_BITS - 1) && !readCmd;
  assign bus.rdLoad = takeBit && bitCount == 5'h07 && shiftIn[6] == 1'b1;
  // Open drain: enable pulls low while the shifted bit is zero.
  assign sdoOe = ~csN & readCmd & (bitCount >= 5'h08)
               & (bitCount != WORD_LAST) & ~shiftOut[7];
endmodule : aofr_serial_port
`default_nettype wire

// file: design/aofr_output_format.sv
// Output format and drive control registers with the output word formatter.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Drive config bit 7 is ignored and reads back as zero.
// - Drive current field selects one of seven LVDS driver currents.
// - Termination bit enables termination and scales current by 1.6.
// - Output disable bit puts all data outputs in high impedance.
// - Test code 000 passes data, 001 forces zeros, 011 forces ones.
// - Code 101 alternates checkerboards, 111 alternates zeros and ones.
// - Two lowest output bits are not forced by any test pattern.
// - Data format bits 7 and 6 are ignored.
// - Data format bit 2 enables alternate bit polarity.
// - Data format bit 1 enables the output randomizer.
// - Test patterns override coding, randomizer and polarity processing.
// - Output disable also floats the sample clock output.
// - Software reset clears both registers to zero.
// - Each access is a 16-bit word: flag, address, data.
module aofr_output_format
  import aofr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial configuration pins.
  input  wire logic        csN,
  input  wire logic        sck,
  input  wire logic        sdi,
  output logic             sdoOut,
  output logic             sdoOe,
  // Sample stream from the converter core.
  input  wire logic        sampleValid,
  input  wire logic [15:0] sampleIn,
  input  wire logic        sampleClockIn,
  // Formatted outputs.
  output logic [15:0]      converted_word,
  output logic             convertedOe,
  output logic             sample_clock_out,
  output logic             sampleClockOe,
  // Analog driver controls.
  output aofr_fmt_type     output_format_sel,
  output logic [2:0]       lvds_drive_current_sel,
  output logic [11:0]      driveCurrent,
  output logic             internal_term_enable,
  output logic             output_tristate
);
  aofr_ser_if ser ();
  logic [7:0] driveCfg;
  logic [7:0] dataFmt;
  logic       phase;

  aofr_serial_port u_port (
    .clk   (clk),
    .rst   (rst),
    .csN   (csN),
    .sck   (sck),
    .sdi   (sdi),
    .sdoOe (sdoOe),
    .bus   (ser.port)
  );
  assign sdoOut = 1'b0;

  // ******************************************************************
  // Registers
  // ******************************************************************
  wire softReset = ser.wrStb && ser.addr == ADDR_RESET_CTRL
                   && ser.wrData[RESET_BIT];
  always_ff @(posedge clk) begin
    if (rst || softReset) begin
      driveCfg <= REG_RESET_VALUE;
      dataFmt  <= REG_RESET_VALUE;
    end else if (ser.wrStb) begin
      if (ser.addr == ADDR_DRIVE_CONFIG) driveCfg <= {1'b0, ser.wrData[6:0]};
      if (ser.addr == ADDR_DATA_FORMAT)  dataFmt  <= {2'b00, ser.wrData[5:0]};
    end
  end
  assign ser.rdData = (ser.addr == ADDR_DRIVE_CONFIG) ? driveCfg :
                      (ser.addr == ADDR_DATA_FORMAT)  ? dataFmt  : 8'h00;

  // ******************************************************************
  // Driver controls
  // ******************************************************************
  assign lvds_drive_current_sel = driveCfg[DRV_CUR_HI:DRV_CUR_LO];
  assign internal_term_enable   = driveCfg[DRV_TERM_BIT];
  assign output_tristate        = driveCfg[DRV_OFF_BIT];
  assign output_format_sel = aofr_fmt_type'(driveCfg[DRV_FMT_HI:DRV_FMT_LO]);
  logic [11:0] baseCurrent;
  always_comb begin
    unique case (lvds_drive_current_sel)
      3'h0:    baseCurrent = CUR_3P5;
      3'h1:    baseCurrent = CUR_4P0;
      3'h2:    baseCurrent = CUR_4P5;
      3'h4:    baseCurrent = CUR_3P0;
      3'h5:    baseCurrent = CUR_2P5;
      3'h6:    baseCurrent = CUR_2P1;
      3'h7:    baseCurrent = CUR_1P75;
      default: baseCurrent = CUR_3P5; // Undefined code; host avoids it.
    endcase
  end
  wire [23:0] scaled = 24'(baseCurrent) * 24'(TERM_NUM) / 24'(TERM_DEN);
  assign driveCurrent = internal_term_enable ? scaled[11:0] : baseCurrent;

  // ******************************************************************
  // Output word formatting
  // ******************************************************************
  // The scrambler flips data bits by the LSB so a receiver can undo it.
  wire [2:0]  testSel  = dataFmt[FMT_TEST_HI:FMT_TEST_LO];
  wire [15:0] coded    = dataFmt[FMT_SIGNED_BIT]
                         ? {~sampleIn[15], sampleIn[14:0]} : sampleIn;
  wire [15:0] scrambled = dataFmt[FMT_OUTPUT_SCRAMBLER_EN_BIT]
                         ? (coded ^ {{15{coded[0]}}, 1'b0}) : coded;
  wire [15:0] polarized = dataFmt[FMT_ABP_BIT]
                         ? (scrambled ^ ABP_MASK) : scrambled;
  logic [15:0] pattern;
  always_comb begin
    unique case (testSel)
      TP_ZEROS:     pattern = 16'h0000;
      TP_ONES:      pattern = 16'hfffc;
      TP_CHECKER:   pattern = phase ? CHECKER_B : CHECKER_A;
      TP_ALTERNATE: pattern = phase ? 16'hfffc : 16'h0000;
      default:      pattern = polarized;
    endcase
  end
  // Patterns win over all processing; low two bits keep the data.
  wire [15:0] next_word = (testSel == TP_OFF) ? polarized
                          : {pattern[15:2], polarized[1:0]};
  always_ff @(posedge clk) begin
    if (rst) begin
      converted_word <= 16'h0000;
      phase          <= 1'b0;
    end else if (sampleValid) begin
      converted_word <= next_word;
      phase          <= ~phase;
    end
  end
  assign convertedOe      = ~output_tristate;
  assign sampleClockOe    = ~output_tristate;
  assign sample_clock_out = sampleClockIn;
endmodule : aofr_output_format
`default_nettype wire

// file: tb/aofr_output_format_props.sv
// Concurrent checks on the ports of the output format block.
`timescale 1ns/1ps
`default_nettype none
module aofr_output_format_props
  import aofr_pkg::*;
(
  input wire logic         clk, rst, csN, sampleValid, sampleClockIn, sdoOut,
  input wire logic         sdoOe,
  input wire logic [15:0]  converted_word,
  input wire logic         convertedOe, sample_clock_out, sampleClockOe,
  input wire aofr_fmt_type output_format_sel,
  input wire logic [2:0]   lvds_drive_current_sel,
  input wire logic [11:0]  driveCurrent,
  input wire logic         internal_term_enable, output_tristate
);
  localparam logic [11:0] CURT [0:7] = '{CUR_3P5, CUR_4P0, CUR_4P5, CUR_3P5,
    CUR_3P0, CUR_2P5, CUR_2P1, CUR_1P75};
  logic [15:0] scaled;
  logic [6:0]  cfg;
  assign scaled = {4'h0, CURT[lvds_drive_current_sel]} * 16'h0010 / 16'h000a;
  assign cfg = {output_format_sel, lvds_drive_current_sel,
    internal_term_enable, output_tristate};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  oe_follow_a: assert property (convertedOe == !output_tristate)
    else $error("data enable disagrees with output disable");
  clk_float_a: assert property (sampleClockOe == convertedOe)
    else $error("clock enable disagrees with data enable");
  clk_pass_a: assert property (sample_clock_out == sampleClockIn)
    else $error("sample clock not passed through");
  reset_clear_a: assert property ($fell(rst) |-> cfg == 7'h00 &&
    converted_word == 16'h0000) else $error("state not cleared by reset");
  cur_map_a: assert property (driveCurrent == (internal_term_enable ?
    scaled[11:0] : CURT[lvds_drive_current_sel]))
    else $error("drive current wrong for code");
  word_hold_a: assert property (!sampleValid |=> $stable(converted_word))
    else $error("output word moved without a sample");
  cfg_hold_a: assert property (csN [*2] |=> $stable(cfg))
    else $error("settings changed outside a frame");
  sdo_drain_a: assert property (sdoOut == 1'b0 && !(csN && sdoOe))
    else $error("serial output driven outside a frame");
  cover property ($rose(output_tristate));
  cover property ($rose(internal_term_enable));
  cover property (sampleValid ##1 !sampleValid);
endmodule : aofr_output_format_props
bind aofr_output_format aofr_output_format_props i_props (.clk, .rst, .csN,
  .sampleValid, .sampleClockIn, .sdoOut, .sdoOe, .converted_word, .convertedOe,
  .sample_clock_out, .sampleClockOe, .output_format_sel,
  .lvds_drive_current_sel, .driveCurrent, .internal_term_enable,
  .output_tristate);
`default_nettype wire

// file: tb/aofr_host_model.sv
// Host controller model that sends serial configuration words.
`timescale 1ns/1ps
`default_nettype none
module aofr_host_model (
  input  wire logic clk,
  input  wire logic sdoOe,
  output var  logic csN,
  output var  logic sck,
  output var  logic sdi
);
  initial csN = 1'b1;
  initial sck = 1'b0;
  initial sdi = 1'b0;
  task automatic xfer(input logic rw, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {rw, a, d};
    q = 8'h00;
    @(posedge clk);
    csN <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      sdi <= w[i];
      sck <= 1'b0;
      @(posedge clk);
      // The line has a pull-up, so a released drain reads as one.
      if (i < 8) q[i] = !sdoOe;
      @(posedge clk);
      sck <= 1'b1;
      @(posedge clk);
    end
    @(posedge clk);
    csN <= 1'b1;
    sck <= 1'b0;
    sdi <= !w[0];
    @(posedge clk);
  endtask : xfer
endmodule : aofr_host_model
`default_nettype wire

// file: tb/test_adc_output_format_config_regs.sv
// Self-checking bench for the output format registers and formatter.
`timescale 1ns/1ps
`default_nettype none
module test_adc_output_format_config_regs
  import aofr_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, sampleValid = 1'b0, sampleClockIn = 1'b0;
  logic [15:0] sampleIn = 16'h0000, converted_word;
  logic csN, sck, sdi, sdoOut, sdoOe, convertedOe, sample_clock_out;
  logic sampleClockOe, internal_term_enable, output_tristate;
  logic [2:0] lvds_drive_current_sel;
  logic [11:0] driveCurrent;
  aofr_fmt_type output_format_sel;
  int err_count = 0, samples_checked = 0, ph = 0;
  logic [31:0] rnd = 32'h43e210a3;
  logic [7:0] m3 = 8'h00, m4 = 8'h00, rd;
  localparam logic [11:0] CURT [0:7] = '{CUR_3P5, CUR_4P0, CUR_4P5, CUR_3P5,
    CUR_3P0, CUR_2P5, CUR_2P1, CUR_1P75};
  localparam logic [2:0] CODES [0:4] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
  always #12.5 clk = ~clk;
  aofr_output_format i_aofr_output_format (.clk, .rst, .csN, .sck, .sdi,
    .sdoOut, .sdoOe, .sampleValid, .sampleIn, .sampleClockIn,
    .converted_word, .convertedOe, .sample_clock_out, .sampleClockOe,
    .output_format_sel, .lvds_drive_current_sel, .driveCurrent,
    .internal_term_enable, .output_tristate);
  aofr_host_model i_host (.clk, .sdoOe, .csN, .sck, .sdi);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic mwr(input logic [6:0] a, input logic [7:0] d);
    if (a == 7'h03) m3 = d & 8'h7f;
    if (a == 7'h04) m4 = d & 8'h3f;
    if (a == 7'h00 && d[7]) {m3, m4} = 16'h0000;
    i_host.xfer(1'b0, a, d, rd);
  endtask : mwr
  task automatic cfgchk();
    logic [15:0] c;
    c = {4'h0, CURT[m3[6:4]]};
    if (m3[3]) c = c * 16'h0010 / 16'h000a;
    chk(16'(output_format_sel), 16'(m3[1:0]));
    chk(16'(driveCurrent), c);
    chk({9'h0, lvds_drive_current_sel, internal_term_enable, output_tristate,
      convertedOe, sampleClockOe},
      {9'h0, m3[6:4], m3[3], m3[2], !m3[2], !m3[2]});
    i_host.xfer(1'b1, 7'h03, 8'hff, rd);
    chk({8'h00, rd}, {8'h00, m3});
    i_host.xfer(1'b1, 7'h04, 8'hff, rd);
    chk({8'h00, rd}, {8'h00, m4});
  endtask : cfgchk
  task automatic smp();
    logic [15:0] e, p, k;
    rnd = lfsr(rnd);
    e = rnd[15:0] ^ (m4[0] ? 16'h8000 : 16'h0000);
    if (m4[1]) e = e ^ {{15{e[0]}}, 1'b0};
    if (m4[2]) e = e ^ ABP_MASK;
    p = (ph % 2) ? CHECKER_B : CHECKER_A;
    if (m4[5:3] == TP_ALTERNATE) p = (ph % 2) ? 16'hffff : 16'h0000;
    if (m4[5:3] == TP_ZEROS) p = 16'h0000;
    if (m4[5:3] == TP_ONES) p = 16'hffff;
    k = (m4[5:3] == TP_OFF) ? 16'hffff : 16'hfffc;
    if (k == 16'hffff) p = e;
    ph++;
    @(posedge clk);
    sampleValid <= 1'b1;
    sampleIn <= rnd[15:0];
    sampleClockIn <= !sampleClockIn;
    @(posedge clk);
    sampleValid <= 1'b0;
    @(posedge clk);
    chk(converted_word & k, p & k);
  endtask : smp
  task automatic final_report();
    $display("mismatches %0d of %0d checks", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cfgchk();
    // Code 011 is skipped because the host must never send it.
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      mwr(7'h03, {rnd[7], (i[2:0] == 3'h3) ? 3'h2 : i[2:0], i[3], rnd[2:0]});
      cfgchk();
      smp();
    end
    mwr(7'h03, 8'h00);
    for (int j = 0; j < 10; j++) begin
      rnd = lfsr(rnd);
      mwr(7'h04, {rnd[7:6], CODES[j / 2], rnd[2:0]});
      cfgchk();
      repeat (4) smp();
    end
    mwr(7'h05, 8'hff);
    i_host.xfer(1'b1, 7'h05, 8'h00, rd);
    chk({8'h00, rd}, 16'h0000);
    mwr(7'h03, 8'h7f);
    mwr(7'h00, 8'h80);
    cfgchk();
    final_report();
  end
endmodule : test_adc_output_format_config_regs
`default_nettype wire
